// ===== rtl/dcc_channel_ctrl.sv
// Purpose: DMA channel controller with queue mapping, completion, linking and chaining.
// Assumes: Classic Wishbone slave, one move request outstanding at a time.
// Notes: Channel n runs descriptor set n; spare sets serve as link targets.
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "dcc_params.svh"
module dcc_channel_ctrl #(
    parameter int NUM_CH = 16,
    parameter int NUM_SETS = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Peripheral events
    input wire logic [NUM_CH-1:0] evt_in,
    // Move requests to the transfer movers
    output logic req_valid,
    input wire logic req_ready,
    output logic [1:0] req_queue,
    output logic [$clog2(NUM_CH)-1:0] req_chan,
    output logic [31:0] req_src,
    output logic [31:0] req_dst,
    output logic [15:0] req_bytes,
    input wire logic move_done
);
    localparam int CW = $clog2(NUM_CH);
    localparam int SW = $clog2(NUM_SETS);

    // ==================================================================
    // Helpers
    function automatic logic [31:0] be_mask(input logic [3:0] sel);
        be_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic [2:0] q_of(input logic [7:0][31:0] qm, input logic [5:0] ch);
        q_of = qm[ch[5:3]][{ch[2:0], 2'b00} +: `DCC_QF_W];
    endfunction

    function automatic logic [CW-1:0] first_one(input logic [NUM_CH-1:0] v);
        first_one = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
            if (v[i])
                first_one = CW'(i);
    endfunction

    function automatic logic [15:0] row_bytes(input logic [31:0] transfer_flags_word, input logic [15:0] acnt);
        if (transfer_flags_word[`DCC_OPT_SAM] | transfer_flags_word[`DCC_OPT_DAM])
            row_bytes = 16'h0001 << transfer_flags_word[`DCC_OPT_FIXED_PORT_WIDTH_HI:`DCC_OPT_FIXED_PORT_WIDTH_LO];
        else
            row_bytes = acnt;
    endfunction

    // ==================================================================
    // Registers and engine state
    logic [7:0][31:0] qmap_reg;
    logic [31:0] rce_reg [0:7];
    logic [31:0] rqe_reg [0:7];
    logic [63:0] pend_reg;
    logic [NUM_CH-1:0] trig_reg;
    logic [NUM_CH-1:0] chain_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    dcc_pkg::dcc_state_e st_reg;
    logic [CW-1:0] ch_reg;
    logic [2:0] wi_reg;
    logic [31:0] opt_reg;
    logic [31:0] src_reg;
    logic [31:0] dst_reg;
    logic [15:0] acnt_reg;
    logic [15:0] bcnt_reg;
    logic [15:0] sbidx_reg;
    logic [15:0] dbidx_reg;
    logic [15:0] link_reg;
    logic [2:0] q_reg;
    logic valid_reg;
    logic [15:0] bytes_reg;
    logic ev_fire_reg;
    logic ev_final_reg;
    logic [5:0] ev_code_reg;

    // ==================================================================
    // Bus decode
    logic wb_req;
    logic wb_go;
    logic wb_wr;
    logic [6:0] bank;
    logic [2:0] idx;
    logic hit_dsc;
    logic eng_we;
    logic [31:0] wmask;

    assign bank = wb_adr_i[11:5];
    assign idx = wb_adr_i[4:2];
    assign hit_dsc = wb_adr_i[11:10] == `DCC_DSC_SEL;
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_reg;
    // A descriptor write waits while the engine owns the store's write port.
    assign wb_go = wb_req & ~(hit_dsc & wb_we_i & eng_we);
    assign wb_wr = wb_go & wb_we_i;
    assign wmask = be_mask(wb_sel_i);

    // ==================================================================
    // Descriptor store and row stepping
    logic [SW+2:0] a_addr;
    logic [SW+2:0] b_addr;
    logic [SW+2:0] w_addr;
    logic [31:0] a_data;
    logic [31:0] b_data;
    logic [31:0] w_data;
    logic w_en;
    logic [31:0] src_nxt;
    logic [31:0] dst_nxt;
    logic [31:0] eng_wdata;

    assign a_addr = wb_adr_i[SW+4:2];
    assign b_addr = (st_reg == dcc_pkg::DCC_LINK) ? {link_reg[SW-1:0], wi_reg}
                                                  : {SW'(ch_reg), wi_reg};
    assign w_en = eng_we | (wb_wr & hit_dsc);
    assign w_addr = eng_we ? {SW'(ch_reg), wi_reg} : a_addr;
    assign w_data = eng_we ? eng_wdata : ((a_data & ~wmask) | (wb_dat_i & wmask));

    always_comb
    begin
        eng_we = 1'b0;
        eng_wdata = b_data;
        if (st_reg == dcc_pkg::DCC_LINK)
            eng_we = 1'b1;
        else if (st_reg == dcc_pkg::DCC_WRBACK)
        begin
            eng_we = 1'b1;
            case (wi_reg)
                `DCC_W_SRC: eng_wdata = src_reg;
                `DCC_W_DST: eng_wdata = dst_reg;
                `DCC_W_CNT: eng_wdata = {bcnt_reg, acnt_reg};
            endcase
        end
    end

    dcc_desc_store #(.AW(SW + 3)) u_store (
        .core_clk(core_clk),
        .wr_en(w_en),
        .wr_addr(w_addr),
        .wr_data(w_data),
        .rd_addr_a(a_addr),
        .rd_data_a(a_data),
        .rd_addr_b(b_addr),
        .rd_data_b(b_data)
    );

    dcc_row_step u_src_step (
        .cur(src_reg),
        .acnt(acnt_reg),
        .bidx(sbidx_reg),
        .fixed_mode(opt_reg[`DCC_OPT_SAM]),
        .ab_sync(opt_reg[`DCC_OPT_ABSYNC]),
        .nxt(src_nxt)
    );

    dcc_row_step u_dst_step (
        .cur(dst_reg),
        .acnt(acnt_reg),
        .bidx(dbidx_reg),
        .fixed_mode(opt_reg[`DCC_OPT_DAM]),
        .ab_sync(opt_reg[`DCC_OPT_ABSYNC]),
        .nxt(dst_nxt)
    );

    // ==================================================================
    // Configuration registers
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            qmap_reg <= '0;
            for (int r = 0; r < 8; r++)
            begin
                rce_reg[r] <= '0;
                rqe_reg[r] <= '0;
            end
        end
        else if (wb_wr)
        begin
            if (bank == `DCC_B_QMAP)
                qmap_reg[idx] <= ((qmap_reg[idx] & ~wmask) | (wb_dat_i & wmask))
                                 & `DCC_QMAP_MASK;
            if (bank == `DCC_B_RCE)
                rce_reg[idx] <= (rce_reg[idx] & ~wmask) | (wb_dat_i & wmask);
            if (bank == `DCC_B_RQE)
                rqe_reg[idx] <= (rqe_reg[idx] & ~wmask) | (wb_dat_i & wmask);
        end
    end

    // ==================================================================
    // Completion pending bits: a new completion wins over a clear.
    logic [63:0] clr_mask;
    logic [63:0] ev_bit;
    logic ev_irq;
    logic ev_chain;

    assign ev_bit = 64'h0000_0000_0000_0001 << ev_code_reg;
    assign ev_irq = ev_fire_reg & (ev_final_reg ? opt_reg[`DCC_OPT_FINAL_DONE_IRQ_EN]
                                                : opt_reg[`DCC_OPT_EARLY_DONE_IRQ_EN]);
    assign ev_chain = ev_fire_reg & (ev_final_reg ? opt_reg[`DCC_OPT_FINAL_DONE_CHAIN_EN]
                                                  : opt_reg[`DCC_OPT_EARLY_DONE_CHAIN_EN]);

    always_comb
    begin
        clr_mask = '0;
        if (wb_wr && bank == `DCC_B_MISC && idx == `DCC_I_CLR_LO)
            clr_mask[31:0] = wb_dat_i & wmask;
        if (wb_wr && bank == `DCC_B_MISC && idx == `DCC_I_CLR_HI)
            clr_mask[63:32] = wb_dat_i & wmask;
        if (wb_wr && bank == `DCC_B_RPEND)
            clr_mask[31:0] = wb_dat_i & wmask & rce_reg[idx];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            pend_reg <= '0;
        else
            pend_reg <= (pend_reg & ~clr_mask) | (ev_irq ? ev_bit : '0);
    end

    // ==================================================================
    // Triggers: peripheral, software set, region set and chaining
    logic [NUM_CH-1:0] avail;
    logic [NUM_CH-1:0] svc;
    logic [NUM_CH-1:0] sw_set;
    logic take;

    assign avail = trig_reg | chain_reg;
    assign take = (st_reg == dcc_pkg::DCC_IDLE) & (|avail);
    assign svc = take ? (NUM_CH'(1) << first_one(avail)) : '0;

    always_comb
    begin
        sw_set = '0;
        if (wb_wr && bank == `DCC_B_MISC && idx == `DCC_I_ESET)
            sw_set = NUM_CH'(wb_dat_i & wmask);
        if (wb_wr && bank == `DCC_B_RESET)
            sw_set = NUM_CH'(wb_dat_i & wmask & rce_reg[idx]);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trig_reg <= '0;
            chain_reg <= '0;
        end
        else
        begin
            trig_reg <= (trig_reg & ~svc) | evt_in | sw_set;
            chain_reg <= (chain_reg & ~svc) | (ev_chain ? ev_bit[NUM_CH-1:0] : '0);
        end
    end

    // ==================================================================
    // Transfer engine
    logic last_row;

    assign last_row = bcnt_reg <= `DCC_ONE_ROW;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= dcc_pkg::DCC_IDLE;
            ch_reg <= '0;
            wi_reg <= '0;
            opt_reg <= '0;
            src_reg <= '0;
            dst_reg <= '0;
            acnt_reg <= '0;
            bcnt_reg <= '0;
            sbidx_reg <= '0;
            dbidx_reg <= '0;
            link_reg <= '0;
            q_reg <= '0;
            valid_reg <= 1'b0;
            bytes_reg <= '0;
            ev_fire_reg <= 1'b0;
            ev_final_reg <= 1'b0;
            ev_code_reg <= '0;
        end
        else
        begin
            ev_fire_reg <= 1'b0;
            unique case (st_reg)
                dcc_pkg::DCC_IDLE:
                begin
                    wi_reg <= '0;
                    if (take)
                    begin
                        ch_reg <= first_one(avail);
                        q_reg <= q_of(qmap_reg, 6'(first_one(avail)));
                        st_reg <= dcc_pkg::DCC_LOAD;
                    end
                end
                dcc_pkg::DCC_LOAD:
                begin
                    case (wi_reg)
                        `DCC_W_OPT: opt_reg <= b_data;
                        `DCC_W_SRC: src_reg <= b_data;
                        `DCC_W_CNT: {bcnt_reg, acnt_reg} <= b_data;
                        `DCC_W_DST: dst_reg <= b_data;
                        `DCC_W_IDX: {dbidx_reg, sbidx_reg} <= b_data;
                        default: link_reg <= b_data[15:0];
                    endcase
                    wi_reg <= wi_reg + 3'h1;
                    if (wi_reg == `DCC_W_LINK)
                    begin
                        valid_reg <= 1'b1;
                        bytes_reg <= row_bytes(opt_reg, acnt_reg);
                        st_reg <= dcc_pkg::DCC_ISSUE;
                    end
                end
                dcc_pkg::DCC_ISSUE:
                begin
                    if (req_ready)
                    begin
                        valid_reg <= 1'b0;
                        ev_code_reg <= opt_reg[`DCC_OPT_TCC_HI:`DCC_OPT_TCC_LO];
                        // Early event as the mover starts; the final one waits for the data unless DCC_OPT_EARLY is set.
                        if (!last_row || opt_reg[`DCC_OPT_EARLY])
                        begin
                            ev_fire_reg <= 1'b1;
                            ev_final_reg <= last_row;
                        end
                        st_reg <= dcc_pkg::DCC_WAIT;
                    end
                end
                dcc_pkg::DCC_WAIT:
                begin
                    wi_reg <= '0;
                    if (move_done)
                    begin
                        src_reg <= src_nxt;
                        dst_reg <= dst_nxt;
                        bcnt_reg <= bcnt_reg - `DCC_ONE_ROW;
                        if (last_row)
                        begin
                            if (!opt_reg[`DCC_OPT_EARLY])
                            begin
                                ev_fire_reg <= 1'b1;
                                ev_final_reg <= 1'b1;
                            end
                            st_reg <= opt_reg[`DCC_OPT_STATIC] ? dcc_pkg::DCC_IDLE
                                                               : dcc_pkg::DCC_LINK;
                        end
                        else if (opt_reg[`DCC_OPT_ABSYNC])
                        begin
                            valid_reg <= 1'b1;
                            st_reg <= dcc_pkg::DCC_ISSUE;
                        end
                        else
                            st_reg <= dcc_pkg::DCC_WRBACK;
                    end
                end
                dcc_pkg::DCC_WRBACK:
                begin
                    // Saves the row position so the next trigger resumes there.
                    wi_reg <= (wi_reg == `DCC_W_OPT) ? `DCC_W_SRC
                            : (wi_reg == `DCC_W_SRC) ? `DCC_W_DST : `DCC_W_CNT;
                    if (wi_reg == `DCC_W_CNT)
                        st_reg <= dcc_pkg::DCC_IDLE;
                end
                dcc_pkg::DCC_LINK:
                begin
                    wi_reg <= wi_reg + 3'h1;
                    if (wi_reg == `DCC_W_LINK)
                        st_reg <= dcc_pkg::DCC_IDLE;
                end
                default:
                    st_reg <= dcc_pkg::DCC_IDLE;
            endcase
        end
    end

    // ==================================================================
    // Status and bus read
    logic [31:0] cstat;
    logic [31:0] tstat;
    logic [31:0] rdata;
    logic busy;

    assign busy = st_reg != dcc_pkg::DCC_IDLE;

    always_comb
    begin
        cstat = '0;
        cstat[`DCC_CS_EVT] = |avail;
        cstat[`DCC_CS_QEVT] = 1'b0;
        cstat[`DCC_CS_TR] = valid_reg;
        cstat[`DCC_CS_WSTAT] = st_reg == dcc_pkg::DCC_WAIT;
        cstat[`DCC_CS_CONTROLLER_BUSY_FLAG] = busy | (|avail);
        cstat[`DCC_CS_COMP] = st_reg == dcc_pkg::DCC_WAIT;
        for (int c = 0; c < NUM_CH; c++)
            if (avail[c])
                cstat[`DCC_CS_QUE + 32'(q_of(qmap_reg, 6'(c)) & 3'h3)] = 1'b1;
        if (busy)
            cstat[`DCC_CS_QUE + 32'(q_reg & 3'h3)] = 1'b1;
        tstat = '0;
        tstat[`DCC_TS_PROG] = busy;
        tstat[`DCC_TS_SRC] = valid_reg;
        tstat[`DCC_TS_WSTAT] = st_reg == dcc_pkg::DCC_WAIT;
        tstat[`DCC_TS_DFIFO] = st_reg == dcc_pkg::DCC_WAIT;
    end

    always_comb
    begin
        rdata = '0;
        if (hit_dsc)
            rdata = a_data;
        else if (bank == `DCC_B_QMAP)
            rdata = qmap_reg[idx];
        else if (bank == `DCC_B_RCE)
            rdata = rce_reg[idx];
        else if (bank == `DCC_B_RQE)
            rdata = rqe_reg[idx];
        else if (bank == `DCC_B_RPEND)
            rdata = pend_reg[31:0] & rce_reg[idx];
        else if (bank == `DCC_B_MISC)
            case (idx)
                `DCC_I_PEND_LO: rdata = pend_reg[31:0];
                `DCC_I_PEND_HI: rdata = pend_reg[63:32];
                `DCC_I_CSTAT: rdata = cstat;
                `DCC_I_TSTAT: rdata = tstat;
                `DCC_I_CHAIN: rdata = 32'(chain_reg);
                default: rdata = '0;
            endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end
        else
        begin
            ack_reg <= wb_go;
            if (wb_go && !wb_we_i)
                dat_reg <= rdata;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign req_valid = valid_reg;
    assign req_queue = q_reg[1:0];
    assign req_chan = ch_reg;
    assign req_src = src_reg;
    assign req_dst = dst_reg;
    assign req_bytes = bytes_reg;
endmodule

// ===== rtl/dcc_params.svh
// Purpose: Named offsets, field positions and status bits of the DMA channel controller.
// Assumes: 12-bit byte address on the register bus, 32-bit words.
// Notes: Definitions only.
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH
// ==================================================================
// Options word fields
`define DCC_OPT_SAM 0
`define DCC_OPT_DAM 1
`define DCC_OPT_ABSYNC 2
`define DCC_OPT_STATIC 3
`define DCC_OPT_FIXED_PORT_WIDTH_LO 8
`define DCC_OPT_FIXED_PORT_WIDTH_HI 10
`define DCC_OPT_EARLY 11
`define DCC_OPT_TCC_LO 12
`define DCC_OPT_TCC_HI 17
`define DCC_OPT_FINAL_DONE_IRQ_EN 20
`define DCC_OPT_EARLY_DONE_IRQ_EN 21
`define DCC_OPT_FINAL_DONE_CHAIN_EN 22
`define DCC_OPT_EARLY_DONE_CHAIN_EN 23
// ==================================================================
// Descriptor word indices
`define DCC_W_OPT 3'h0
`define DCC_W_SRC 3'h1
`define DCC_W_CNT 3'h2
`define DCC_W_DST 3'h3
`define DCC_W_IDX 3'h4
`define DCC_W_LINK 3'h5
`define DCC_ONE_ROW 16'h0001
// ==================================================================
// Queue map layout
`define DCC_QF_W 3
`define DCC_QMAP_MASK 32'h7777_7777
// ==================================================================
// Register bank numbers, byte address bits 11:5
`define DCC_B_QMAP 7'h00
`define DCC_B_MISC 7'h01
`define DCC_B_RCE 7'h02
`define DCC_B_RQE 7'h03
`define DCC_B_RPEND 7'h04
`define DCC_B_RESET 7'h05
`define DCC_DSC_SEL 2'h1
// Word index inside the misc bank
`define DCC_I_PEND_LO 3'h0
`define DCC_I_PEND_HI 3'h1
`define DCC_I_CLR_LO 3'h2
`define DCC_I_CLR_HI 3'h3
`define DCC_I_CSTAT 3'h4
`define DCC_I_TSTAT 3'h5
`define DCC_I_ESET 3'h6
`define DCC_I_CHAIN 3'h7
// ==================================================================
// Status bits
`define DCC_CS_EVT 0
`define DCC_CS_QEVT 1
`define DCC_CS_TR 2
`define DCC_CS_WSTAT 3
`define DCC_CS_CONTROLLER_BUSY_FLAG 4
`define DCC_CS_COMP 8
`define DCC_CS_QUE 16
`define DCC_TS_PROG 0
`define DCC_TS_SRC 1
`define DCC_TS_WSTAT 2
`define DCC_TS_DFIFO 4
`endif

// ===== rtl/dcc_pkg.sv
// Purpose: Types shared by the DMA channel controller.
// Assumes: Nothing.
// Notes: Engine states.
package dcc_pkg;
    typedef enum logic [2:0] {
        DCC_IDLE, DCC_LOAD, DCC_ISSUE, DCC_WAIT, DCC_WRBACK, DCC_LINK
    } dcc_state_e;
endpackage

// ===== rtl/dcc_desc_store.sv
// Purpose: Transfer descriptor store, eight words per set.
// Assumes: One write port, two asynchronous read ports.
// Notes: No reset; software loads sets before use.
`timescale 1ns/1ns
module dcc_desc_store #(
    parameter int AW = 8
) (
    // Clock
    input wire logic core_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [31:0] wr_data,
    // Read ports
    input wire logic [AW-1:0] rd_addr_a,
    output logic [31:0] rd_data_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [31:0] rd_data_b
);
    logic [31:0] mem [0:(1<<AW)-1];

    always_ff @(posedge core_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];
endmodule

// ===== rtl/dcc_row_step.sv
// Purpose: Address of the next row of a two-dimensional transfer.
// Assumes: Signed 16-bit row skip.
// Notes: Used once for source and once for destination.
`timescale 1ns/1ns
module dcc_row_step (
    // Current row
    input wire logic [31:0] cur,
    input wire logic [15:0] acnt,
    input wire logic [15:0] bidx,
    // Mode
    input wire logic fixed_mode,
    input wire logic ab_sync,
    // Result
    output logic [31:0] nxt
);
    logic [31:0] skip;

    assign skip = {{16{bidx[15]}}, bidx};

    // A-sync steps past the previous row's last byte; AB-sync from its start.
    always_comb
    begin
        if (fixed_mode)
            nxt = cur;
        else if (ab_sync)
            nxt = cur + skip;
        else
            nxt = cur + {16'h0000, acnt} + skip;
    end
endmodule

// ===== test/dcc_mover_model.sv
// Purpose: Transfer mover on the far side of the move link.
// Assumes: One row in flight at a time.
// Notes: slow stretches each row so the bench can look in mid-move.
`timescale 1ns/1ns
// ========================================
// Mover model
module dcc_mover_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Move link
    input wire logic req_valid,
    output logic req_ready,
    output logic move_done,
    // Pace
    input wire logic slow
);
    logic [5:0] left_reg;
    logic held_reg;
    // Accepting only while idle keeps a single row outstanding; slow also stalls one cycle.
    assign req_ready = req_valid && left_reg == 6'h00 && (held_reg || !slow);
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            held_reg <= 1'h0;
        else
            held_reg <= req_valid && !req_ready;
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            left_reg <= 6'h00;
        else if (req_ready)
            left_reg <= slow ? 6'h20 : 6'h02;
        else if (left_reg != 6'h00)
            left_reg <= left_reg - 6'h01;
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            move_done <= 1'h0;
        else
            move_done <= left_reg == 6'h01;
endmodule

// ===== test/dcc_channel_ctrl_asserts.sv
// Purpose: Port checks of the DMA channel controller.
// Assumes: The mover keeps one row outstanding.
// Notes: Bound to every controller instance.
`timescale 1ns/1ns
// ========================================
// Checker
module dcc_cc_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // Move link
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [31:0] req_src,
    input wire logic [31:0] req_dst,
    input wire logic [15:0] req_bytes,
    input wire logic move_done
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic row_out_reg;
    sequence s_accept; req_valid && req_ready; endsequence
    sequence s_bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            row_out_reg <= 1'h0;
        else if (req_valid && req_ready)
            row_out_reg <= 1'h1;
        else if (move_done)
            row_out_reg <= 1'h0;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_ack_bound: assert property (s_bus_req |-> ##[1:8] wb_ack_o)
        else $error("bus request not answered");
    a_dat_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved without ack");
    a_req_hold: assert property (req_valid && !req_ready |=> req_valid && $stable(req_src)
        && $stable(req_dst) && $stable(req_bytes))
        else $error("request changed before acceptance");
    a_one_row: assert property (row_out_reg |-> !req_valid)
        else $error("second row before move done");
    a_row_gap: assert property (s_accept |=> !req_valid [*2])
        else $error("request too soon after accept");
    a_reset_quiet: assert property ($rose(arst_n) |-> !req_valid && !wb_ack_o)
        else $error("outputs busy after reset");
endmodule
bind dcc_channel_ctrl dcc_cc_chk dcc_cc_chk_i (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i,
    .wb_ack_o, .wb_dat_o, .req_valid, .req_ready, .req_src, .req_dst, .req_bytes, .move_done);

// ===== test/tb.sv
// Purpose: Self-checking bench of the DMA channel controller.
// Assumes: The mover model answers every request.
// Notes: Register rows first, then transfers on channels 3, 1 and 2.
`timescale 1ns/1ns
// ========================================
// Bench
module tb;
    logic core_clk, arst_n, cyc, stb, we, slow, ack, req_valid, req_ready, move_done;
    logic [11:0] adr;
    logic [31:0] wdat, rdat, dat_o, req_src, req_dst;
    logic [15:0] evt, req_bytes;
    logic [1:0] req_queue;
    logic [3:0] req_chan;
    logic [31:0] q_src[$], q_dst[$], q_meta[$];
    int fails = 0, checks_done = 0;
    logic [75:0] rows [5] = '{{12'h008, 32'hFFFF_FFFF, 32'h7777_7777},
        {12'h000, 32'h8000_2018, 32'h0000_2010}, {12'h300, 32'hFFFF_FFFF, 32'h0},
        {12'h020, 32'hFFFF_FFFF, 32'h0}, {12'h03C, 32'hFFFF_FFFF, 32'h0}};
    // Set 3: one static row with final interrupt, code 5; set 1: AB rows, fixed source.
    // Set 2: two static A-sync rows with early interrupt, code 7.
    logic [43:0] dsc [15] = '{{12'h460, 32'h0010_5008}, {12'h464, 32'h1000},
        {12'h468, 32'h0001_0010}, {12'h46C, 32'h2000}, {12'h470, 32'h0},
        {12'h420, 32'h0000_020D}, {12'h424, 32'h1000}, {12'h428, 32'h0002_0010},
        {12'h42C, 32'h3000}, {12'h430, 32'h0040_0000}, {12'h440, 32'h0020_7008},
        {12'h444, 32'h1000}, {12'h448, 32'h0002_0010}, {12'h44C, 32'h5000},
        {12'h450, 32'h0020_0000}};
    dcc_channel_ctrl dcc_channel_ctrl_i (.core_clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .evt_in(evt), .req_valid, .req_ready, .req_queue, .req_chan,
        .req_src, .req_dst, .req_bytes, .move_done);
    dcc_mover_model dcc_mover_model_i (.core_clk, .arst_n, .req_valid, .req_ready,
        .move_done, .slow);
    initial
    begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (req_valid && req_ready)
        begin
            q_src.push_back(req_src);
            q_dst.push_back(req_dst);
            q_meta.push_back({4'h0, req_chan, 6'h0, req_queue, req_bytes});
        end
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do @(posedge core_clk); while (ack !== 1'h1);
        rdat = dat_o;
        {cyc, stb} <= 2'h0;
    endtask
    task end_sim;
        if (fails == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        {arst_n, cyc, stb, we, adr, wdat, evt, slow} = 0;
        slow = 1'h1;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'h1;
        foreach (rows[i])
        begin
            bus(1'h1, rows[i][75:64], rows[i][63:32]);
            bus(1'h0, rows[i][75:64], 32'h0);
            chk(rdat, rows[i][31:0]);
        end
        foreach (dsc[i])
            bus(1'h1, dsc[i][43:32], dsc[i][31:0]);
        bus(1'h1, 12'h038, 32'h8);
        repeat (100) if (q_src.size() < 1) @(posedge core_clk);
        bus(1'h0, 12'h020, 32'h0);
        chk(rdat, 32'h0);
        chk(q_meta[0], {4'h0, 4'h3, 6'h0, 2'h2, 16'h0010});
        chk(q_src[0] ^ q_dst[0], 32'h3000);
        repeat (40) @(posedge core_clk);
        bus(1'h0, 12'h020, 32'h0);
        chk(rdat, 32'h20);
        bus(1'h1, 12'h028, 32'h20);
        bus(1'h0, 12'h020, 32'h0);
        chk(rdat, 32'h0);
        chk(32'(q_src.size()), 32'h1);
        slow <= 1'h0;
        evt <= 16'h0002;
        @(posedge core_clk);
        evt <= 16'h0000;
        repeat (200) @(posedge core_clk);
        chk(32'(q_src.size()), 32'h3);
        chk(q_meta[1], {4'h0, 4'h1, 6'h0, 2'h1, 16'h0004});
        chk(q_src[2], 32'h1000);
        chk(q_dst[2], 32'h3040);
        bus(1'h1, 12'h038, 32'h4);
        repeat (50) @(posedge core_clk);
        chk(32'(q_src.size()), 32'h4);
        chk(q_meta[3], {4'h0, 4'h2, 6'h0, 2'h0, 16'h0010});
        bus(1'h0, 12'h020, 32'h0);
        chk(rdat, 32'h80);
        bus(1'h1, 12'h038, 32'h4);
        repeat (50) @(posedge core_clk);
        chk(q_src[4], 32'h1010);
        chk(q_dst[4], 32'h5030);
        bus(1'h0, 12'h008, 32'h0);
        chk(rdat, 32'h7777_7777);
        arst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        chk(dat_o, 32'h0);
        arst_n <= 1'h1;
        bus(1'h0, 12'h008, 32'h0);
        chk(rdat, 32'h0);
        end_sim;
    end
    initial
    begin
        #200000;
        fails++;
        end_sim;
    end
endmodule
